// *** core/tfs_supervisor.sv ***
// Overview of operation
// R1 - over-temp fault clears only once temperature is 5 C below its level
// R2 - behaviour 00 keeps running, 10 disables and follows the retry setting, 01/11 unsupported
// R3 - over-temp fault pulls the alert line low and sets its status bit
// R4 - retry 000 keeps the rail off until restarted; 001-110 unsupported
// R5 - retry 111 restarts forever until commanded off or another shutdown
// R6 - delay code gives 25 ms per step, 0 for 000, 175 ms for 111
// R7 - action setting resets to 84h, latch off with delay code 100
// R8 - warning level is signed, 1 C per step, usable 0 to 150 C
// R9 - warning level resets to 006Eh, 110 C
// R10 - under-temp level is signed, 1 C per step, resets to FFD8h
// R11 - host keeps the under-temp level between -50 C and 150 C
// R12 - over-temp fault level is unsigned, resets to 125 C, trips above it
// R13 - under-temp fault clears only once temperature is 5 C above its level
// R14 - every page keeps its own settings; host access goes to selected page
// R15 - above the warning level a warning flag is raised, rail keeps running
`timescale 1ns/1ps
module tfs_supervisor #(
   parameter int unsigned retry_step_cycles = tfs_pkg::RETRY_STEP_CYCLES
) (
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic                        cmd_write,
   input  wire logic                        cmd_read,
   input  wire logic [7:0]                  cmd_code,
   input  wire logic                        cmd_page,
   input  wire logic [15:0]                 cmd_wdata,
   output logic      [15:0]                 cmd_rdata,
   output logic                             cmd_rvalid,
   input  wire tfs_pkg::tfs_temp_type       temp_sense,
   input  wire logic [tfs_pkg::PAGES-1:0]   rail_on_pin,
   input  wire logic [tfs_pkg::PAGES-1:0]   other_shutdown,
   output logic      [tfs_pkg::PAGES-1:0]   rail_enable,
   output tfs_pkg::tfs_status_bus_type      status,
   output logic                             fault_alert_line_n
);
   import tfs_pkg::*;

   // ---------------------------------------------
   // command decode
   // ---------------------------------------------
   // 0 = unmapped, 1..4 = the four settings
   function automatic logic [2:0] cmd_index(input logic [7:0] code);
      case (code)
         CMD_OVERTEMP_FAULT_LEVEL:  cmd_index = 3'h1;
         CMD_OVERTEMP_FAULT_ACTION: cmd_index = 3'h2;
         CMD_OVERTEMP_WARNING:      cmd_index = 3'h3;
         CMD_UNDERTEMP_FAULT_LEVEL: cmd_index = 3'h4;
         default:                   cmd_index = 3'h0;
      endcase
   endfunction

   tfs_cfg_type      cfg      [PAGES];
   logic [PAGES-1:0] rail_sync1;
   logic [PAGES-1:0] rail_sync2;
   logic [PAGES-1:0] alert_any;

   // ---------------------------------------------
   // rail control pin synchroniser
   // ---------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         rail_sync1 <= '0;
         rail_sync2 <= '0;
      end else begin
         rail_sync1 <= rail_on_pin;
         rail_sync2 <= rail_sync1;
      end
   end

   // ---------------------------------------------
   // per-page settings, comparators and response
   // ---------------------------------------------
   for (genvar g = 0; g < PAGES; g++) begin : gen_page
      tfs_cfg_type    next_cfg;
      tfs_status_type flags;
      tfs_status_type next_flags;
      tfs_state_type  state;
      tfs_state_type  next_state;
      logic [31:0]    cnt;
      logic [31:0]    next_cnt;
      logic [31:0]    delay_cycles;
      logic [17:0]    temp_x;
      logic [17:0]    ot_x;
      logic [17:0]    warn_x;
      logic [17:0]    ut_x;
      logic [1:0]     behav;
      logic [2:0]     retry;

      // settings writes for this page only
      always_comb begin
         next_cfg = cfg[g];
         if (cmd_write && (cmd_page == 1'(g))) begin // [R14]
            case (cmd_index(cmd_code))
               3'h1:    next_cfg.ot_level  = cmd_wdata;
               3'h2:    next_cfg.ot_action = cmd_wdata[7:0];
               3'h3:    next_cfg.ot_warn   = cmd_wdata;
               3'h4:    next_cfg.ut_level  = cmd_wdata;
               default: next_cfg = cfg[g];
            endcase
         end
      end

      always_ff @(posedge mclk) begin
         if (rst) begin
            cfg[g].ot_level  <= RST_OVERTEMP_FAULT_LEVEL;   // [R12]
            cfg[g].ot_action <= RST_OVERTEMP_FAULT_ACTION;  // [R7]
            cfg[g].ot_warn   <= RST_OVERTEMP_WARNING;       // [R9]
            cfg[g].ut_level  <= RST_UNDERTEMP_FAULT_LEVEL;  // [R10]
         end else begin
            cfg[g] <= next_cfg;
         end
      end

      // 18-bit signed views of temperature and levels
      assign temp_x = {{2{temp_sense[g][15]}}, temp_sense[g]};
      assign ot_x   = {2'h0, cfg[g].ot_level};                      // [R12]
      assign warn_x = {{2{cfg[g].ot_warn[15]}}, cfg[g].ot_warn};    // [R8]
      assign ut_x   = {{2{cfg[g].ut_level[15]}}, cfg[g].ut_level};  // [R10]

      // fault flags with hysteresis, warning flag without
      always_comb begin
         next_flags = flags;
         if ($signed(temp_x) > $signed(ot_x))
            next_flags.ot_fault = 1'b1;                                   // [R12]
         else if ($signed(temp_x) <= $signed(ot_x - HYST_DEGC))
            next_flags.ot_fault = 1'b0;                                   // [R1]
         next_flags.ot_warn = $signed(temp_x) > $signed(warn_x);          // [R15]
         if ($signed(temp_x) < $signed(ut_x))
            next_flags.ut_fault = 1'b1;
         else if ($signed(temp_x) >= $signed(ut_x + HYST_DEGC))
            next_flags.ut_fault = 1'b0;                                   // [R13]
      end

      always_ff @(posedge mclk) begin
         if (rst) begin
            flags <= '0;
         end else begin
            flags <= next_flags;
         end
      end

      assign behav        = cfg[g].ot_action[BEHAV_MSB:BEHAV_LSB];
      assign retry        = cfg[g].ot_action[RETRY_MSB:RETRY_LSB];
      // one step per code, so 111 gives seven steps
      assign delay_cycles = 32'(cfg[g].ot_action[DELAY_MSB:DELAY_LSB])
                            * 32'(retry_step_cycles);             // [R6]

      // rail response state machine
      always_comb begin
         next_state = state;
         next_cnt   = cnt;
         case (state)
            ST_OFF: begin
               if (rail_sync2[g] && !other_shutdown[g]) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (!rail_sync2[g]) begin
                  next_state = ST_OFF;
               end else if (other_shutdown[g]) begin
                  next_state = ST_LATCHED;
               end else if (flags.ot_fault && behav == BEHAV_DISABLE) begin // [R2]
                  next_cnt = '0;
                  if (retry == RETRY_ALWAYS)
                     next_state = ST_WAIT;                                  // [R5]
                  else
                     next_state = ST_LATCHED;                               // [R4]
               end
            end
            ST_WAIT: begin
               if (!rail_sync2[g]) begin
                  next_state = ST_OFF;                                      // [R5]
               end else if (other_shutdown[g]) begin
                  next_state = ST_LATCHED;                                  // [R5]
               end else if (cnt >= delay_cycles) begin
                  next_state = ST_RUN;                                      // [R6]
               end else begin
                  next_cnt = cnt + 32'h1;
               end
            end
            ST_LATCHED: begin
               if (!rail_sync2[g]) begin
                  next_state = ST_OFF;                                      // [R4]
               end
            end
            default: next_state = ST_OFF;
         endcase
      end

      always_ff @(posedge mclk) begin
         if (rst) begin
            state <= ST_OFF;
            cnt   <= '0;
         end else begin
            state <= next_state;
            cnt   <= next_cnt;
         end
      end

      // outputs of this page
      assign rail_enable[g] = (state == ST_RUN) && rail_sync2[g] && !other_shutdown[g];
      assign status[g]      = flags;                                        // [R3]
      assign alert_any[g]   = flags.ot_fault || flags.ut_fault;
   end

   // ---------------------------------------------
   // alert line and readback
   // ---------------------------------------------
   logic        alert_n;
   logic        next_alert_n;
   logic [15:0] next_rdata;

   always_comb begin
      next_alert_n = !(|alert_any);                                 // [R3]
      next_rdata   = '0;
      case (cmd_index(cmd_code))
         3'h1:    next_rdata = cfg[cmd_page].ot_level;              // [R14]
         3'h2:    next_rdata = {8'h00, cfg[cmd_page].ot_action};
         3'h3:    next_rdata = cfg[cmd_page].ot_warn;
         3'h4:    next_rdata = cfg[cmd_page].ut_level;
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         alert_n    <= 1'b1;
         cmd_rdata  <= '0;
         cmd_rvalid <= 1'b0;
      end else begin
         alert_n    <= next_alert_n;
         cmd_rdata  <= cmd_read ? next_rdata : cmd_rdata;
         cmd_rvalid <= cmd_read;
      end
   end

   assign fault_alert_line_n = alert_n;

endmodule

// *** core/tfs_pkg.sv ***
package tfs_pkg;

   // ---------------------------------------------
   // geometry
   // ---------------------------------------------
   localparam int unsigned PAGES = 2;

   // ---------------------------------------------
   // command codes
   // ---------------------------------------------
   localparam logic [7:0] CMD_OVERTEMP_FAULT_LEVEL  = 8'h4F;
   localparam logic [7:0] CMD_OVERTEMP_FAULT_ACTION = 8'h50;
   localparam logic [7:0] CMD_OVERTEMP_WARNING      = 8'h51;
   localparam logic [7:0] CMD_UNDERTEMP_FAULT_LEVEL = 8'h53;

   // ---------------------------------------------
   // reset values
   // ---------------------------------------------
   localparam logic [15:0] RST_OVERTEMP_FAULT_LEVEL  = 16'h007D;
   localparam logic [7:0]  RST_OVERTEMP_FAULT_ACTION = 8'h84;
   localparam logic [15:0] RST_OVERTEMP_WARNING      = 16'h006E;
   localparam logic [15:0] RST_UNDERTEMP_FAULT_LEVEL = 16'hFFD8;

   // ---------------------------------------------
   // action field layout and codes
   // ---------------------------------------------
   localparam int unsigned BEHAV_MSB = 7;
   localparam int unsigned BEHAV_LSB = 6;
   localparam int unsigned RETRY_MSB = 5;
   localparam int unsigned RETRY_LSB = 3;
   localparam int unsigned DELAY_MSB = 2;
   localparam int unsigned DELAY_LSB = 0;
   localparam logic [1:0] BEHAV_CONTINUE = 2'h0;
   localparam logic [1:0] BEHAV_DISABLE  = 2'h2;
   localparam logic [2:0] RETRY_NONE     = 3'h0;
   localparam logic [2:0] RETRY_ALWAYS   = 3'h7;

   // ---------------------------------------------
   // temperature and timing
   // ---------------------------------------------
   localparam logic [17:0] HYST_DEGC        = 18'h00005;
   localparam int unsigned CLK_KHZ          = 125000;
   localparam int unsigned RETRY_STEP_MS    = 25;
   localparam int unsigned RETRY_STEP_CYCLES = RETRY_STEP_MS * CLK_KHZ;

   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef struct packed {
      logic [15:0] ot_level;
      logic [7:0]  ot_action;
      logic [15:0] ot_warn;
      logic [15:0] ut_level;
   } tfs_cfg_type;

   typedef struct packed {
      logic ot_fault;
      logic ot_warn;
      logic ut_fault;
   } tfs_status_type;

   typedef logic [PAGES-1:0][15:0] tfs_temp_type;
   typedef tfs_status_type [PAGES-1:0] tfs_status_bus_type;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_RUN,
      ST_WAIT,
      ST_LATCHED
   } tfs_state_type;

endpackage

// *** testbench/tfs_supervisor_sva.sv ***
`timescale 1ns/1ps
module tfs_supervisor_sva import tfs_pkg::*; #(
   parameter int unsigned retry_step_cycles = 10
) (
   input wire logic                       mclk,
   input wire logic                       rst,
   input wire logic                       cmd_write,
   input wire logic                       cmd_read,
   input wire logic [7:0]                 cmd_code,
   input wire logic                       cmd_page,
   input wire logic [15:0]                cmd_wdata,
   input wire logic [15:0]                cmd_rdata,
   input wire logic                       cmd_rvalid,
   input wire tfs_pkg::tfs_temp_type      temp_sense,
   input wire logic [tfs_pkg::PAGES-1:0]  rail_on_pin,
   input wire logic [tfs_pkg::PAGES-1:0]  other_shutdown,
   input wire logic [tfs_pkg::PAGES-1:0]  rail_enable,
   input wire tfs_pkg::tfs_status_bus_type status,
   input wire logic                       fault_alert_line_n
);
   logic [15:0]        lvl, next_lvl;
   logic [7:0]         act, next_act;
   logic signed [17:0] t0, l0;
   logic               flt;
   // page 0 level and action snooped from host writes
   always_comb begin
      next_lvl = lvl;
      next_act = act;
      if (cmd_write && !cmd_page && cmd_code == CMD_OVERTEMP_FAULT_LEVEL)
         next_lvl = cmd_wdata;
      if (cmd_write && !cmd_page && cmd_code == CMD_OVERTEMP_FAULT_ACTION)
         next_act = cmd_wdata[7:0];
   end
   always_ff @(posedge mclk) begin
      lvl <= rst ? RST_OVERTEMP_FAULT_LEVEL : next_lvl;
      act <= rst ? RST_OVERTEMP_FAULT_ACTION : next_act;
   end
   // signed views and any-fault summary
   assign t0 = {{2{temp_sense[0][15]}}, temp_sense[0]};
   assign l0 = {2'h0, lvl};
   assign flt = status[0].ot_fault | status[0].ut_fault | status[1].ot_fault | status[1].ut_fault;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   alert_low_a: assert property (flt |=> !fault_alert_line_n)
      else $error("alert not low on fault");
   alert_high_a: assert property (!flt |=> fault_alert_line_n)
      else $error("alert low without fault");
   read_answer_a: assert property (cmd_rvalid == $past(cmd_read))
      else $error("read answer timing wrong");
   rdata_hold_a: assert property (!cmd_rvalid |-> $stable(cmd_rdata))
      else $error("read data moved without answer");
   ot_trip_a: assert property (t0 > l0 |=> status[0].ot_fault)
      else $error("over-temp fault not raised");
   ot_hold_a: assert property (status[0].ot_fault && t0 > l0 - 18'sd5 |=> status[0].ot_fault)
      else $error("over-temp fault cleared early");
   ot_off_a: assert property (status[0].ot_fault && rail_enable[0] && act[7:6] == 2'h2
      |=> !rail_enable[0])
      else $error("rail not disabled on fault");
   pin_sync_a: assert property (rail_enable[0] |-> $past(rail_on_pin[0], 2))
      else $error("rail runs while commanded off");
   shut_off_a: assert property (other_shutdown[0] |-> !rail_enable[0])
      else $error("rail runs during shutdown");
endmodule
bind tfs_supervisor tfs_supervisor_sva #(.retry_step_cycles(retry_step_cycles)) chk_u (
   .mclk, .rst, .cmd_write, .cmd_read, .cmd_code, .cmd_page, .cmd_wdata, .cmd_rdata,
   .cmd_rvalid, .temp_sense, .rail_on_pin, .other_shutdown, .rail_enable, .status,
   .fault_alert_line_n);

// *** testbench/tfs_host_model.sv ***
`timescale 1ns/1ps
module tfs_host_model (
   input  wire logic        mclk,
   input  wire logic [15:0] cmd_rdata,
   input  wire logic        cmd_rvalid,
   output logic             cmd_write,
   output logic             cmd_read,
   output logic [7:0]       cmd_code,
   output logic             cmd_page,
   output logic [15:0]      cmd_wdata
);
   // idle host at time zero
   initial begin
      {cmd_write, cmd_read, cmd_code, cmd_page, cmd_wdata} = '0;
   end
   // one write strobe, data bus released as its inverse
   task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
      @(negedge mclk);
      {cmd_write, cmd_page, cmd_code, cmd_wdata} = {1'b1, p, c, d};
      @(negedge mclk);
      cmd_write = 1'b0;
      cmd_wdata = ~d;
   endtask
   // read strobe, answer taken one cycle later
   task automatic rd(input logic p, input logic [7:0] c, output logic [16:0] r);
      @(negedge mclk);
      {cmd_read, cmd_page, cmd_code} = {1'b1, p, c};
      @(negedge mclk);
      cmd_read = 1'b0;
      r = {cmd_rvalid, cmd_rdata};
   endtask
endmodule

// *** testbench/test_tfs_supervisor.sv ***
`timescale 1ns/1ps
module test_tfs_supervisor;
   import tfs_pkg::*;
   localparam int STEP = 10;
   logic mclk = 0, rst = 1, cmd_write, cmd_read, cmd_page, cmd_rvalid, fault_alert_line_n;
   logic [7:0] cmd_code, cd[5] = '{8'h4F, 8'h50, 8'h51, 8'h53, 8'h52};
   logic [15:0] cmd_wdata, cmd_rdata, lf = 16'h005C, v[2][4];
   logic [16:0] r;
   logic [1:0] rail_on_pin = 0, other_shutdown = 0, rail_enable;
   logic ot[2] = '{0, 0}, w[2] = '{0, 0}, ut[2] = '{0, 0};
   tfs_temp_type temp_sense = {16'd25, 16'd25};
   tfs_status_bus_type status;
   int n_mismatch, samples_checked, cyc, rg[2][int], t[2] = '{25, 25}, k, n;
   logic [2:0] k_d[3] = '{3'h0, 3'h3, 3'h7};
   tfs_supervisor #(.retry_step_cycles(STEP)) dut_u (.mclk, .rst, .cmd_write, .cmd_read,
      .cmd_code, .cmd_page, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .temp_sense, .rail_on_pin,
      .other_shutdown, .rail_enable, .status, .fault_alert_line_n);
   tfs_host_model host_u (.mclk, .cmd_rdata, .cmd_rvalid, .cmd_write, .cmd_read, .cmd_code,
      .cmd_page, .cmd_wdata);
   initial forever #4 mclk = ~mclk;
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done;
      end
   end
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int sg(input int x);
      return int'($signed(16'(x)));
   endfunction
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
      host_u.wr(p, c, d);
      if (rg[p].exists(c)) rg[p][c] = (c == 8'h50) ? int'(d[7:0]) : int'(d);
   endtask
   task automatic rchk(input logic p, input logic [7:0] c);
      host_u.rd(p, c, r);
      chk(r === {1'b1, 16'(rg[p].exists(c) ? rg[p][c] : 0)}, "read value");
   endtask
   // flag model for the temperature now applied
   task automatic upd(input int p);
      ot[p] = ot[p] ? t[p] > rg[p][8'h4F] - 5 : t[p] > rg[p][8'h4F];
      w[p] = t[p] > sg(rg[p][8'h51]);
      ut[p] = ut[p] ? t[p] < sg(rg[p][8'h53]) + 5 : t[p] < sg(rg[p][8'h53]);
   endtask
   task automatic gap;
      for (k = 0; rail_enable[0] && k < 300; k++) @(negedge mclk);
      for (n = 0; !rail_enable[0] && n < 300; n++) @(negedge mclk);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // main sequence
   initial begin
      foreach (rg[p]) rg[p] = '{8'h4F: 'h7D, 8'h50: 'h84, 8'h51: 'h6E, 8'h53: 'hFFD8};
      v = '{'{16'h007D, 16'h003F, 16'h006E, 16'hFFD8}, '{16'h007D, 16'h0084, 16'hFFCE, 16'hFFD8}};
      repeat (12) @(negedge mclk);
      rst = 0;
      chk(rail_enable === 2'b00 && fault_alert_line_n === 1'b1, "reset outputs");
      foreach (cd[c]) foreach (rg[p]) rchk(p[0], cd[c]);
      $display("test defaults done");
      foreach (cd[c]) foreach (rg[p]) begin
         lf = nxt(lf);
         wr(p[0], cd[c], (c == 3) ? 16'(int'(lf % 200) - 50) : lf);
      end
      foreach (cd[c]) foreach (rg[p]) rchk(p[0], cd[c]);
      $display("test paged access done");
      foreach (v[p, c]) wr(p[0], cd[c], v[p][c]);
      rail_on_pin = 2'b11;
      repeat (10) @(negedge mclk);
      foreach (t[p]) upd(p);
      chk(rail_enable === 2'b11, "rails not up");
      repeat (400) begin
         @(negedge mclk);
         foreach (t[p]) begin
            chk(status[p] === {ot[p], w[p], ut[p]}, "flags");
            lf = nxt(lf);
            t[p] = (p ? -38 : 122) + int'(lf % 25) - 12;
            temp_sense[p] = 16'(t[p]);
            upd(p);
         end
         chk(rail_enable[0] === 1'b1, "rail dropped");
      end
      $display("test temperature walk done");
      wr(0, 8'h50, 16'h008C);
      temp_sense[0] = 16'd130;
      repeat (5) @(negedge mclk);
      chk(rail_enable[0] === 1'b0 && status[0].ot_fault === 1'b1, "no latch");
      temp_sense[0] = 16'd25;
      repeat (20) @(negedge mclk);
      chk(rail_enable[0] === 1'b0, "latch released");
      rail_on_pin[0] = 1'b0;
      repeat (4) @(negedge mclk);
      rail_on_pin[0] = 1'b1;
      repeat (6) @(negedge mclk);
      chk(rail_enable[0] === 1'b1, "no restart");
      $display("test latch off done");
      // heat only once retry is armed, else the latch-off setting would trip
      foreach (k_d[i]) begin
         wr(0, 8'h50, {8'h00, 2'b10, 3'b111, k_d[i]});
         temp_sense[0] = 16'd130;
         gap;
         gap;
         chk(n >= k_d[i] * STEP && n <= k_d[i] * STEP + 3, "retry delay");
      end
      other_shutdown[0] = 1'b1;
      repeat (2) @(negedge mclk);
      other_shutdown[0] = 1'b0;
      gap;
      chk(n == 300, "retry after shutdown");
      $display("test retry done");
      test_done;
   end
endmodule
